// *** pkg/idp_pkg.sv ***
// Shared constants, types and ECC helper functions for the identification page block.
package idp_pkg;
  // Core clock period and the AHB word size code.
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // Serial opcodes; reads and writes of the page and the lock share two codes.
  localparam logic [7:0] OPC_ID_READ = 8'h83;
  localparam logic [7:0] OPC_ID_WRITE = 8'h82;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  // Bit 2 of the middle address byte is page_sel_bit; bit 1 of the lock data byte arms the lock.
  localparam int PSEL_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;
  // Address byte index that carries the low eight address bits.
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Page of 256 bytes held as 64 groups of four bytes.
  localparam logic [6:0] GROUPS = 7'h40;
  localparam int CW_LEN = 38;
  // Register byte offsets and field positions.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_BP_LO = 0;
  localparam int CTRL_BP_HI = 1;
  localparam int CTRL_SWD = 7;
  localparam int STAT_WIP = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_LOCK = 2;
  localparam int STAT_ECC = 3;

  // Serial command sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP} idp_state_e;

  // Places 32 data bits at the non power of two positions of a 38-bit Hamming word.
  function automatic logic [38:1] idp_spread(input logic [31:0] d);
    logic [38:1] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CW_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    return c;
  endfunction : idp_spread

  // Pulls the 32 data bits back out of a Hamming word.
  function automatic logic [31:0] idp_gather(input logic [38:1] c);
    logic [31:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p <= CW_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction : idp_gather

  // XOR of the positions of all set bits; zero for a clean word.
  function automatic logic [5:0] idp_syndrome(input logic [38:1] c);
    logic [5:0] s;
    s = '0;
    for (int p = 1; p <= CW_LEN; p++) begin
      if (c[p]) begin
        s = s ^ p[5:0];
      end
    end
    return s;
  endfunction : idp_syndrome
endpackage : idp_pkg

// *** rtl/idp_sync.sv ***
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module idp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);
  // First stage is read only by the second stage, so metastability never reaches logic.
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Both stages take the idle pin level under reset.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;
endmodule : idp_sync
`default_nettype wire

// *** rtl/idp_ecc.sv ***
// Single-bit correcting code over one four-byte group: encoder and corrector.
`timescale 1ns/1ps
`default_nettype none
module idp_ecc
  import idp_pkg::*;
(
  input wire logic [31:0] enc_data,
  output logic [5:0] enc_check,
  input wire logic [31:0] dec_data,
  input wire logic [5:0] dec_check,
  output logic [31:0] dec_fixed,
  output logic dec_err
);
  logic [38:1] dec_cw;
  logic [5:0] dec_syn;

  // Check bits sit at power of two positions, so the data syndrome is the check word.
  always_comb begin
    enc_check = idp_syndrome(idp_spread(enc_data));
  end

  // Rebuild the stored word, then flip the bit the syndrome points at.
  always_comb begin
    dec_cw = idp_spread(dec_data);
    for (int i = 0; i < 6; i++) begin
      dec_cw[1 << i] = dec_check[i];
    end
    dec_syn = idp_syndrome(dec_cw);
    dec_err = (dec_syn != 6'h00);
    // A syndrome past the word means a multi-bit fault; it is left uncorrected.
    if (dec_err && (dec_syn <= 6'(CW_LEN))) begin
      dec_cw[dec_syn] = ~dec_cw[dec_syn];
    end
    dec_fixed = idp_gather(dec_cw);
  end
endmodule : idp_ecc
`default_nettype wire

// *** rtl/idp_core.sv ***
// Serial identification page, its lock (held until sys_rst clears it) and the AHB-Lite register slave.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module idp_core
  import idp_pkg::*;
#(
  parameter int WRITE_CYCLE_NS = 5000000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_sel_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // Self-timed write length in core cycles, rounded up.
  localparam int WR_CYC_I = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] WR_CYC = 24'(WR_CYC_I);

  // Whole module state; the two arrays below are memories and live outside it.
  typedef struct packed {
    idp_state_e st;
    logic [2:0] bits;
    logic [1:0] abyte;
    logic [6:0] shin;
    logic [7:0] opc;
    logic psel;
    logic [7:0] ptr;
    logic [7:0] shout;
    logic drv;
    logic got_data;
    logic lock_req;
    logic sel_d;
    logic sck_d;
    logic write_enable_latch;
    logic write_in_progress;
    logic lock;
    logic lock_pend;
    logic [23:0] wcnt;
    logic [6:0] sweep;
    logic [255:0] pv;
    logic bp_lo;
    logic bp_hi;
    logic swd;
    logic ecc_hit;
    logic a_vld;
    logic a_wr;
    logic [7:0] a_off;
    logic [31:0] rdata;
  } idp_core_s;

  idp_core_s r_ff;
  idp_core_s nxt_r;

  // Page storage: data plus six check bits per group, and the pending write bytes.
  logic [37:0] mem [64];
  logic [7:0] pdat [256];

  logic sel_s, sck_s, mosi_s;
  logic sel_rise, sel_fall, sck_rise, sck_fall;
  logic [7:0] byte_in;
  logic [5:0] rd_grp;
  logic [31:0] rd_fixed, merged;
  logic [5:0] wr_check;
  logic rd_err, pend_we, mem_we, take;
  logic [7:0] rd_byte;

  // All three pins come from the master's domain and are synchronised first.
  idp_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({spi_sel_n, spi_sck, spi_mosi}),
    .pin_sync({sel_s, sck_s, mosi_s})
  );

  // One read port serves both the serial read and the write-cycle group sweep.
  assign rd_grp = r_ff.write_in_progress ? r_ff.sweep[5:0] : r_ff.ptr[7:2];

  idp_ecc u_ecc (
    .enc_data(merged),
    .enc_check(wr_check),
    .dec_data(mem[rd_grp][31:0]),
    .dec_check(mem[rd_grp][37:32]),
    .dec_fixed(rd_fixed),
    .dec_err(rd_err)
  );

  // Merge pending bytes over the corrected group so the whole group is rewritten.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = r_ff.pv[{rd_grp, 2'(b)}] ? pdat[{rd_grp, 2'(b)}] : rd_fixed[b*8 +: 8];
    end
  end

  // Register read decode; unmapped offsets read as zero.
  function automatic logic [31:0] reg_read(input idp_core_s s, input logic [7:0] off);
    logic [31:0] v;
    v = '0;
    if (off == REG_CTRL) begin
      v[CTRL_BP_LO] = s.bp_lo;
      v[CTRL_BP_HI] = s.bp_hi;
      v[CTRL_SWD] = s.swd;
    end else if (off == REG_STAT) begin
      v[STAT_WIP] = s.write_in_progress;
      v[STAT_WEL] = s.write_enable_latch;
      v[STAT_LOCK] = s.lock;
      v[STAT_ECC] = s.ecc_hit;
    end
    return v;
  endfunction : reg_read

  // Next-state logic for the serial sequencer, write cycle and register slave.
  always_comb begin
    nxt_r = r_ff;
    pend_we = 1'b0;
    mem_we = 1'b0;
    sel_rise = sel_s & ~r_ff.sel_d;
    sel_fall = ~sel_s & r_ff.sel_d;
    sck_rise = sck_s & ~r_ff.sck_d;
    sck_fall = ~sck_s & r_ff.sck_d;
    byte_in = {r_ff.shin, mosi_s};
    // Lock status byte has zero upper bits; page data comes through the corrector.
    rd_byte = r_ff.psel ? {7'h00, r_ff.lock} : rd_fixed[r_ff.ptr[1:0]*8 +: 8];
    take = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
    nxt_r.sel_d = sel_s;
    nxt_r.sck_d = sck_s;

    // Self-timed write: sweep touched groups first, then run out the timer.
    if (r_ff.write_in_progress) begin
      if (r_ff.sweep != GROUPS) begin
        mem_we = |r_ff.pv[{r_ff.sweep[5:0], 2'h0} +: 4];
        nxt_r.pv[{r_ff.sweep[5:0], 2'h0} +: 4] = 4'h0;
        nxt_r.sweep = r_ff.sweep + 7'h01;
      end
      nxt_r.wcnt = r_ff.wcnt - 24'h000001;
      if (r_ff.wcnt == 24'h000001) begin
        nxt_r.write_in_progress = 1'b0;
        if (r_ff.lock_pend) begin
          nxt_r.lock = 1'b1;
        end
        nxt_r.lock_pend = 1'b0;
      end
    end

    if (sel_s) begin
      // Deselected: output released, sequencer parked.
      nxt_r.st = ST_IDLE;
      nxt_r.drv = 1'b0;
      if (sel_rise) begin
        // Commit needs a whole data byte, the latch, no busy, no full protection.
        if (r_ff.st == ST_DIN && r_ff.bits == 3'h0 && r_ff.got_data && r_ff.write_enable_latch && !r_ff.write_in_progress
            && !(r_ff.bp_hi && r_ff.bp_lo) && (r_ff.psel ? r_ff.lock_req : !r_ff.lock)) begin
          nxt_r.write_in_progress = 1'b1;
          nxt_r.wcnt = WR_CYC;
          nxt_r.sweep = 7'h00;
          nxt_r.write_enable_latch = 1'b0;
          nxt_r.lock_pend = r_ff.psel;
        end else if (r_ff.opc == OPC_WRITE_ENABLE_CMD && r_ff.st == ST_SKIP && !r_ff.write_in_progress) begin
          nxt_r.write_enable_latch = 1'b1;
        end
      end
    end else if (sel_fall) begin
      // New command; stale pending bytes from a dropped write are forgotten.
      nxt_r.st = ST_OPC;
      nxt_r.bits = 3'h0;
      nxt_r.got_data = 1'b0;
      nxt_r.lock_req = 1'b0;
      if (!r_ff.write_in_progress) begin
        nxt_r.pv = '0;
      end
    end else if (sck_rise && r_ff.st != ST_IDLE) begin
      nxt_r.shin = byte_in[6:0];
      nxt_r.bits = r_ff.bits + 3'h1;
      if (r_ff.bits == BIT_LAST) begin
        case (r_ff.st)
          ST_OPC: begin
            nxt_r.opc = byte_in;
            nxt_r.abyte = 2'h0;
            // Busy device executes none of the page commands.
            if (!r_ff.write_in_progress && (byte_in == OPC_ID_READ || byte_in == OPC_ID_WRITE)) begin
              nxt_r.st = ST_ADDR;
            end else begin
              nxt_r.st = ST_SKIP;
            end
          end
          ST_ADDR: begin
            // Three address bytes; only page_sel_bit and the low byte matter.
            nxt_r.abyte = r_ff.abyte + 2'h1;
            if (r_ff.abyte == 2'h1) begin
              nxt_r.psel = byte_in[PSEL_BIT];
            end
            if (r_ff.abyte == ADDR_LAST) begin
              nxt_r.ptr = byte_in;
              nxt_r.st = (r_ff.opc == OPC_ID_READ) ? ST_DOUT : ST_DIN;
            end
          end
          ST_DIN: begin
            nxt_r.got_data = 1'b1;
            if (r_ff.psel) begin
              nxt_r.lock_req = byte_in[LOCK_DATA_BIT];
            end else begin
              pend_we = 1'b1;
              nxt_r.pv[r_ff.ptr] = 1'b1;
              nxt_r.ptr = r_ff.ptr + 8'h01;
            end
          end
          ST_DOUT: begin
            // Page reads advance; the lock status byte repeats.
            if (!r_ff.psel) begin
              nxt_r.ptr = r_ff.ptr + 8'h01;
            end
          end
          default: begin
            nxt_r.st = r_ff.st;
          end
        endcase
      end
    end else if (sck_fall && r_ff.st == ST_DOUT) begin
      // Load a fresh byte at each byte start, otherwise shift MSB first.
      if (r_ff.bits == 3'h0) begin
        nxt_r.shout = rd_byte;
        nxt_r.drv = 1'b1;
        nxt_r.ecc_hit = rd_err & ~r_ff.psel;
      end else begin
        nxt_r.shout = {r_ff.shout[6:0], 1'b0};
      end
    end

    // AHB-Lite: zero wait states; read data is prepared at the address phase.
    nxt_r.a_vld = take;
    nxt_r.a_wr = hwrite;
    nxt_r.a_off = haddr[7:0];
    if (take && !hwrite) begin
      nxt_r.rdata = reg_read(r_ff, haddr[7:0]);
    end
    if (r_ff.a_vld && r_ff.a_wr && r_ff.a_off == REG_CTRL) begin
      nxt_r.bp_lo = hwdata[CTRL_BP_LO];
      nxt_r.bp_hi = hwdata[CTRL_BP_HI];
      nxt_r.swd = hwdata[CTRL_SWD];
    end
  end

  // Reset brings the device up idle, deselected, latch and busy cleared.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_ff <= '0;
      r_ff.sel_d <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Memories carry no reset; contents survive power cycles in the real part.
  always_ff @(posedge clk) begin
    if (pend_we) begin
      pdat[r_ff.ptr] <= byte_in;
    end
    if (mem_we) begin
      mem[r_ff.sweep[5:0]] <= {wr_check, merged};
    end
  end

  assign spi_miso = r_ff.shout[7];
  assign spi_miso_oe_n = ~r_ff.drv;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = r_ff.rdata;

  // Cycles since the write cycle began, for checking its length.
  logic [23:0] ast_wlen;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ast_wlen <= '0;
    end else begin
      ast_wlen <= r_ff.write_in_progress ? ast_wlen + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_DESEL_FLOAT: assert property (sel_s && r_ff.sel_d |-> spi_miso_oe_n)
    else $error("Output driven while deselected");
  AST_READ_NOT_BUSY: assert property ($rose(r_ff.drv) |-> !r_ff.write_in_progress)
    else $error("Read executed during write cycle");
  AST_WIP_FROM_SEL: assert property ($rose(r_ff.write_in_progress) |-> $past(sel_rise) && !$past(r_ff.write_in_progress))
    else $error("Write cycle started without select rise");
  AST_WIP_LENGTH: assert property ($fell(r_ff.write_in_progress) |-> $past(ast_wlen) == WR_CYC - 24'h000001)
    else $error("Write cycle length wrong");
  AST_LOCK_STICKY: assert property ($past(r_ff.lock) |-> r_ff.lock)
    else $error("Lock released");
  AST_LOCK_BYTE: assert property ($rose(r_ff.drv) && r_ff.psel |-> r_ff.shout == {7'h00, r_ff.lock})
    else $error("Lock status byte wrong");
  AST_PROTECT: assert property ($rose(r_ff.write_in_progress) |-> !(r_ff.bp_hi && r_ff.bp_lo) && $past(r_ff.write_enable_latch))
    else $error("Write cycle under full protection or no latch");
  AST_LOCKED_NO_WRITE: assert property ($rose(r_ff.write_in_progress) && !r_ff.lock_pend |-> !r_ff.lock)
    else $error("Page write accepted while locked");
  AST_LOCK_AFTER: assert property ($fell(r_ff.write_in_progress) && $past(r_ff.lock_pend) |-> r_ff.lock)
    else $error("Lock not set after lock cycle");
endmodule : idp_core
`default_nettype wire

// *** verification/idp_spi_master.sv ***
// Behavioural serial bus master that drives frames into the identification page block.
`timescale 1ns/1ps
`default_nettype none
module idp_spi_master (
  input wire logic clk,
  output var logic spi_sel_n,
  output var logic spi_sck,
  output var logic spi_mosi,
  input wire logic miso_w
);
  // Bytes sent from index 4 on, and bytes captured per frame.
  logic [7:0] tx [0:299];
  logic [7:0] rx [0:299];
  // Core clock edges per half period of the serial clock, giving a 200 ns period.
  localparam int HALF = 4;

  // Sends opcode, three address bytes, then data; nbits may stop mid-byte.
  task automatic frame(input logic [7:0] op, input logic [7:0] mid, input logic [7:0] lo, input int nbits);
    logic [7:0] sh;
    sh = 8'h00;
    tx[0] = op;
    tx[1] = 8'h00;
    tx[2] = mid;
    tx[3] = lo;
    @(posedge clk);
    spi_sel_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi <= tx[i / 8][7 - (i % 8)];
      repeat (HALF) @(posedge clk);
      spi_sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      // Sampled at the end of the high phase, since the output lags the fall by several core clocks.
      sh = {sh[6:0], miso_w};
      spi_sck <= 1'b0;
      if ((i % 8) == 7) begin
        rx[i / 8] = sh;
      end
    end
    repeat (HALF) @(posedge clk);
    spi_sel_n <= 1'b1;
    // A released data line must not look like a held bit.
    spi_mosi <= ~spi_mosi;
    repeat (4 * HALF) @(posedge clk);
  endtask : frame

  // The clock stands low between frames.
  initial begin
    spi_sel_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
endmodule : idp_spi_master
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the identification page block and its register bus.
`timescale 1ns/1ps
`default_nettype none
`define IDP_CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import idp_pkg::*;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, oe_n, miso, miso_w, last_q, seen;
  logic sel_n, sck, mosi;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] page [0:255];
  int fails, checks, cyc, a;

  idp_core #(.WRITE_CYCLE_NS(25000)) idp_core_inst (.clk(clk), .sys_rst(sys_rst), .spi_sel_n(sel_n),
    .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  idp_spi_master idp_spi_master_inst (.clk(clk), .spi_sel_n(sel_n), .spi_sck(sck), .spi_mosi(mosi),
    .miso_w(miso_w));

  // A floating data line shows the inverse of its last driven bit.
  assign miso_w = (oe_n === 1'b0) ? miso : ~last_q;
  always @(posedge clk) begin
    cyc++;
    if (oe_n === 1'b0) begin
      last_q <= miso;
      seen <= 1'b1;
    end
    if (cyc > 80000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Xorshift source with a fixed start, so runs repeat.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // One single-word bus transfer; waits on hready in both phases.
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    `IDP_CHK("hresp", HRESP_OKAY, hresp)
  endtask : ahb

  // Polls the status word until the write cycle is over, under a bound.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      ahb(1'b0, REG_STAT, 32'h0);
      n++;
    end while (q[STAT_WIP] !== 1'b0 && n < 1000);
    `IDP_CHK("wip_end", 1'b0, q[STAT_WIP])
  endtask : wait_idle

  // Reads n page bytes from start s and compares them with the expected copy.
  task automatic rd_chk(input int s, input int n);
    idp_spi_master_inst.frame(OPC_ID_READ, 8'h00, s[7:0], 32 + 8 * n);
    for (int i = 0; i < n; i++) begin
      `IDP_CHK("page_byte", page[s + i], idp_spi_master_inst.rx[4 + i])
    end
  endtask : rd_chk

  // Reads the lock byte three times in one frame.
  task automatic ls_chk(input logic v);
    idp_spi_master_inst.frame(OPC_ID_READ, 8'h04, 8'h00, 56);
    for (int i = 4; i < 7; i++) begin
      `IDP_CHK("lock_byte", {7'h00, v}, idp_spi_master_inst.rx[i])
    end
  endtask : ls_chk

  task automatic write_enable_cmd();
    idp_spi_master_inst.frame(OPC_WRITE_ENABLE_CMD, 8'h00, 8'h00, 8);
  endtask : write_enable_cmd

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    {hsel, hwrite, last_q, seen} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    seed = 32'hC58A;
    {fails, checks, cyc} = 0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    `IDP_CHK("oe_rst", 1'b1, oe_n)
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("stat_rst", 32'h0, q)
    a = rnd();
    ahb(1'b1, REG_CTRL, a);
    ahb(1'b0, REG_CTRL, 32'h0);
    `IDP_CHK("ctrl_rw", a & 32'h83, q)
    ahb(1'b1, 32'h8, a);
    ahb(1'b0, 32'h8, 32'h0);
    `IDP_CHK("unmapped", 32'h0, q)
    ahb(1'b1, REG_CTRL, 32'h0);
    // Whole page in one frame, then reads refused while the cycle runs.
    for (int i = 0; i < 256; i++) begin
      page[i] = 8'(rnd());
      idp_spi_master_inst.tx[4 + i] = page[i];
    end
    write_enable_cmd();
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("wel_set", 1'b1, q[STAT_WEL])
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h00, 8'h00, 32 + 2048);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("wip_set", 1'b1, q[STAT_WIP])
    seen = 1'b0;
    idp_spi_master_inst.frame(OPC_ID_READ, 8'h00, 8'h00, 40);
    idp_spi_master_inst.frame(OPC_ID_READ, 8'h04, 8'h00, 40);
    `IDP_CHK("busy_read", 1'b0, seen)
    wait_idle();
    rd_chk(0, 256);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("ecc_clean", 1'b0, q[STAT_ECC])
    // One byte rewrites its group; neighbours must survive.
    a = rnd() & 32'hFF;
    page[a] = 8'(rnd());
    idp_spi_master_inst.tx[4] = page[a];
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h00, a[7:0], 40);
    wait_idle();
    rd_chk(a & 32'hFC, 4);
    // Without the enable latch the write is dropped.
    idp_spi_master_inst.tx[4] = ~page[a];
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h00, a[7:0], 40);
    rd_chk(a, 1);
    idp_spi_master_inst.frame(OPC_ID_READ, 8'h00, a[7:0], 36);
    `IDP_CHK("oe_abort", 1'b1, oe_n)
    // Both protect bits refuse page and lock writes.
    ahb(1'b1, REG_CTRL, 32'h3);
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h00, 8'h00, 40);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("prot_wr", 1'b0, q[STAT_WIP])
    idp_spi_master_inst.tx[4] = 8'h02;
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h04, 8'h00, 40);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("prot_lock", 1'b0, q[STAT_WIP])
    ahb(1'b1, REG_CTRL, 32'h0);
    // A second reset clears the latch.
    write_enable_cmd();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("stat_rst2", 1'b0, q[STAT_WEL])
    ls_chk(1'b0);
    // Lock cut mid-byte, then with bit one clear, then properly.
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h04, 8'h00, 36);
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("lock_cut", 2'h0, {q[STAT_LOCK], q[STAT_WIP]})
    idp_spi_master_inst.tx[4] = 8'hFD;
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h04, 8'h00, 40);
    wait_idle();
    ls_chk(1'b0);
    idp_spi_master_inst.tx[4] = 8'h02;
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h04, 8'h00, 40);
    wait_idle();
    ahb(1'b0, REG_STAT, 32'h0);
    `IDP_CHK("locked", 1'b1, q[STAT_LOCK])
    ls_chk(1'b1);
    idp_spi_master_inst.tx[4] = ~page[5];
    write_enable_cmd();
    idp_spi_master_inst.frame(OPC_ID_WRITE, 8'h00, 8'h05, 40);
    wait_idle();
    rd_chk(5, 1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
